// *** odu_decode_table.sv ***
// Combinational decode table for opcodes D0 through FF.
// Assumes the opcode is stable for the cycle; below D0 it answers not valid.
`timescale 1ns/1ps
module odu_decode_table
	import odu_pkg::*;
(
	odu_dec_if.table_side dec
);
	// One table lookup; codes below the range fall through as not valid.
	always_comb begin
		dec.valid = 1'b1;
		dec.op = ODU_OP_NONE;
		dec.form = ODU_FORM_NONE;
		dec.length = ODU_LEN_1;
		dec.reg_index = dec.opcode[2:0];
		dec.index_r1 = dec.opcode[0];
		dec.absolute = 1'b0;
		dec.relative = 1'b0;
		dec.page_bits = dec.opcode[7:5];
		if (dec.opcode < ODU_RANGE_BASE) begin
			dec.valid = 1'b0;
			dec.length = ODU_LEN_0;
		end else if (dec.opcode[7:3] == ODU_ROW_DBNZ_REG) begin
			// RULE7: register decrement branch
			dec.op = ODU_OP_DECREMENT_BRANCH_NONZERO;
			dec.form = ODU_FORM_REGISTER_REL;
			dec.length = ODU_LEN_2;
			dec.relative = 1'b1;
		end else if (dec.opcode[7:3] == ODU_ROW_LOAD_REG) begin
			// RULE12: load from register
			dec.op = ODU_OP_LOAD_ACCUMULATOR;
			dec.form = ODU_FORM_REGISTER;
		end else if (dec.opcode[7:3] == ODU_ROW_STORE_REG) begin
			// RULE17: store to register
			dec.op = ODU_OP_STORE_ACCUMULATOR;
			dec.form = ODU_FORM_REGISTER;
		end else if (dec.opcode[4:0] == ODU_CALL_LOW &&
			(dec.opcode[7:5] == ODU_CALL_HIGH_D || dec.opcode[7:5] == ODU_CALL_HIGH_F)) begin
			// RULE2: absolute call pair
			dec.op = ODU_OP_ABSOLUTE_CALL;
			dec.form = ODU_FORM_CODE_ADDR;
			dec.length = ODU_LEN_2;
			dec.absolute = 1'b1;
		end else begin
			unique case (dec.opcode)
				// RULE1: stack pull direct
				ODU_OPC_STACK_PULL: begin
					dec.op = ODU_OP_STACK_PULL;
					dec.form = ODU_FORM_DIRECT;
					dec.length = ODU_LEN_2;
				end
				// RULE4: set bit forms
				ODU_OPC_SET_BIT_DIRECT: begin
					dec.op = ODU_OP_SET_BIT;
					dec.form = ODU_FORM_BIT_ADDR;
					dec.length = ODU_LEN_2;
				end
				ODU_OPC_SET_BIT_CARRY: begin
					dec.op = ODU_OP_SET_BIT;
					dec.form = ODU_FORM_CARRY;
				end
				// RULE18: accumulator one-byte ops
				ODU_OPC_DECIMAL_ADJUST: begin
					dec.op = ODU_OP_DECIMAL_ADJUST;
					dec.form = ODU_FORM_ACCUMULATOR;
				end
				ODU_OPC_CLEAR_ACC: begin
					dec.op = ODU_OP_CLEAR_ACCUMULATOR;
					dec.form = ODU_FORM_ACCUMULATOR;
				end
				ODU_OPC_COMPLEMENT: begin
					dec.op = ODU_OP_COMPLEMENT;
					dec.form = ODU_FORM_ACCUMULATOR;
				end
				// RULE5: direct decrement branch
				ODU_OPC_DBNZ_DIRECT: begin
					dec.op = ODU_OP_DECREMENT_BRANCH_NONZERO;
					dec.form = ODU_FORM_DIRECT_REL;
					dec.length = ODU_LEN_3;
					dec.relative = 1'b1;
				end
				// RULE6: nibble exchange indirect
				ODU_OPC_EXCHANGE_LOW_NIBBLE_R0, ODU_OPC_EXCHANGE_LOW_NIBBLE_R1: begin
					dec.op = ODU_OP_EXCHANGE_LOW_NIBBLE;
					dec.form = ODU_FORM_INDIRECT;
				end
				// RULE8: external read pointer
				ODU_OPC_EXT_READ_DATA_POINTER: begin
					dec.op = ODU_OP_EXTERNAL_READ;
					dec.form = ODU_FORM_DATA_POINTER;
				end
				// RULE3: absolute jump
				ODU_OPC_ABS_JUMP: begin
					dec.op = ODU_OP_ABSOLUTE_JUMP;
					dec.form = ODU_FORM_CODE_ADDR;
					dec.length = ODU_LEN_2;
					dec.absolute = 1'b1;
				end
				// RULE9: external read indirect
				ODU_OPC_EXT_READ_R0, ODU_OPC_EXT_READ_R1: begin
					dec.op = ODU_OP_EXTERNAL_READ;
					dec.form = ODU_FORM_INDIRECT;
				end
				// RULE10: load from direct
				ODU_OPC_LOAD_DIRECT: begin
					dec.op = ODU_OP_LOAD_ACCUMULATOR;
					dec.form = ODU_FORM_DIRECT;
					dec.length = ODU_LEN_2;
				end
				// RULE11: load from indirect
				ODU_OPC_LOAD_R0, ODU_OPC_LOAD_R1: begin
					dec.op = ODU_OP_LOAD_ACCUMULATOR;
					dec.form = ODU_FORM_INDIRECT;
				end
				// RULE13: external write pointer
				ODU_OPC_EXT_WRITE_DATA_POINTER: begin
					dec.op = ODU_OP_EXTERNAL_WRITE;
					dec.form = ODU_FORM_DATA_POINTER;
				end
				// RULE14: external write indirect
				ODU_OPC_EXT_WRITE_R0, ODU_OPC_EXT_WRITE_R1: begin
					dec.op = ODU_OP_EXTERNAL_WRITE;
					dec.form = ODU_FORM_INDIRECT;
				end
				// RULE15: store to direct
				ODU_OPC_STORE_DIRECT: begin
					dec.op = ODU_OP_STORE_ACCUMULATOR;
					dec.form = ODU_FORM_DIRECT;
					dec.length = ODU_LEN_2;
				end
				// RULE16: store to indirect
				ODU_OPC_STORE_R0, ODU_OPC_STORE_R1: begin
					dec.op = ODU_OP_STORE_ACCUMULATOR;
					dec.form = ODU_FORM_INDIRECT;
				end
				default: begin
					dec.valid = 1'b0;
					dec.length = ODU_LEN_0;
				end
			endcase
		end
	end
endmodule

// *** odu_pkg.sv ***
// Package for the upper-range opcode decoder: opcode codes, operation and operand enumerations, lengths.
// Assumes an 8-bit opcode byte and a 16-bit program counter on the core clock.
package odu_pkg;
	// Operations decoded in the upper opcode range.
	typedef enum logic [3:0] {
		ODU_OP_NONE,
		ODU_OP_STACK_PULL,
		ODU_OP_ABSOLUTE_CALL,
		ODU_OP_ABSOLUTE_JUMP,
		ODU_OP_SET_BIT,
		ODU_OP_DECIMAL_ADJUST,
		ODU_OP_DECREMENT_BRANCH_NONZERO,
		ODU_OP_EXCHANGE_LOW_NIBBLE,
		ODU_OP_EXTERNAL_READ,
		ODU_OP_EXTERNAL_WRITE,
		ODU_OP_CLEAR_ACCUMULATOR,
		ODU_OP_COMPLEMENT,
		ODU_OP_LOAD_ACCUMULATOR,
		ODU_OP_STORE_ACCUMULATOR
	} odu_op_t;

	// Operand forms.
	typedef enum logic [3:0] {
		ODU_FORM_NONE,
		ODU_FORM_DIRECT,
		ODU_FORM_CODE_ADDR,
		ODU_FORM_BIT_ADDR,
		ODU_FORM_CARRY,
		ODU_FORM_ACCUMULATOR,
		ODU_FORM_DIRECT_REL,
		ODU_FORM_INDIRECT,
		ODU_FORM_REGISTER_REL,
		ODU_FORM_DATA_POINTER,
		ODU_FORM_REGISTER
	} odu_form_t;

	localparam logic [7:0] ODU_RANGE_BASE = 8'hD0;
	localparam logic [7:0] ODU_OPC_STACK_PULL = 8'hD0;
	localparam logic [7:0] ODU_OPC_SET_BIT_DIRECT = 8'hD2;
	localparam logic [7:0] ODU_OPC_SET_BIT_CARRY = 8'hD3;
	localparam logic [7:0] ODU_OPC_DECIMAL_ADJUST = 8'hD4;
	localparam logic [7:0] ODU_OPC_DBNZ_DIRECT = 8'hD5;
	localparam logic [7:0] ODU_OPC_EXCHANGE_LOW_NIBBLE_R0 = 8'hD6;
	localparam logic [7:0] ODU_OPC_EXCHANGE_LOW_NIBBLE_R1 = 8'hD7;
	localparam logic [7:0] ODU_OPC_EXT_READ_DATA_POINTER = 8'hE0;
	localparam logic [7:0] ODU_OPC_ABS_JUMP = 8'hE1;
	localparam logic [7:0] ODU_OPC_EXT_READ_R0 = 8'hE2;
	localparam logic [7:0] ODU_OPC_EXT_READ_R1 = 8'hE3;
	localparam logic [7:0] ODU_OPC_CLEAR_ACC = 8'hE4;
	localparam logic [7:0] ODU_OPC_LOAD_DIRECT = 8'hE5;
	localparam logic [7:0] ODU_OPC_LOAD_R0 = 8'hE6;
	localparam logic [7:0] ODU_OPC_LOAD_R1 = 8'hE7;
	localparam logic [7:0] ODU_OPC_EXT_WRITE_DATA_POINTER = 8'hF0;
	localparam logic [7:0] ODU_OPC_EXT_WRITE_R0 = 8'hF2;
	localparam logic [7:0] ODU_OPC_EXT_WRITE_R1 = 8'hF3;
	localparam logic [7:0] ODU_OPC_COMPLEMENT = 8'hF4;
	localparam logic [7:0] ODU_OPC_STORE_DIRECT = 8'hF5;
	localparam logic [7:0] ODU_OPC_STORE_R0 = 8'hF6;
	localparam logic [7:0] ODU_OPC_STORE_R1 = 8'hF7;
	// Row bases of the eight-register groups (low three bits select the register).
	localparam logic [4:0] ODU_ROW_DBNZ_REG = 5'h1B;
	localparam logic [4:0] ODU_ROW_LOAD_REG = 5'h1D;
	localparam logic [4:0] ODU_ROW_STORE_REG = 5'h1F;
	// Low five bits shared by both absolute call opcodes.
	localparam logic [4:0] ODU_CALL_LOW = 5'h11;
	localparam logic [2:0] ODU_CALL_HIGH_D = 3'h6;
	localparam logic [2:0] ODU_CALL_HIGH_F = 3'h7;

	localparam logic [1:0] ODU_LEN_0 = 2'h0;
	localparam logic [1:0] ODU_LEN_1 = 2'h1;
	localparam logic [1:0] ODU_LEN_2 = 2'h2;
	localparam logic [1:0] ODU_LEN_3 = 2'h3;
	// Absolute targets keep the top five bits of the next instruction's address.
	localparam int ODU_PAGE_BITS = 11;
	localparam int ODU_PC_WIDTH = 16;
endpackage

// *** odu_dec_if.sv ***
// Interface carrying one decoded opcode from the decode table to the registering top.
// Assumes both ends sit in the same clock domain; purely combinational signals.
`timescale 1ns/1ps
interface odu_dec_if;
	import odu_pkg::*;
	logic [7:0] opcode;
	logic valid;
	odu_op_t op;
	odu_form_t form;
	logic [1:0] length;
	logic [2:0] reg_index;
	logic index_r1;
	logic absolute;
	logic relative;
	logic [2:0] page_bits;

	modport table_side (input opcode, output valid, op, form, length, reg_index, index_r1, absolute, relative,
		page_bits);
	modport user_side (output opcode, input valid, op, form, length, reg_index, index_r1, absolute, relative,
		page_bits);
endinterface

// *** odu_decoder.sv ***
// Top of the upper-range opcode decoder: registers decode results and forms branch and page targets.
// Assumes the fetch unit presents opcode, operand byte and instruction address with a one-cycle strobe.
`timescale 1ns/1ps
// Function
// RULE1: D0 is a two-byte stack pull with a direct data address.
// RULE2: D1 and F1 are two-byte absolute calls, address from opcode bits and byte two.
// RULE3: E1 is a two-byte absolute jump with a code address.
// RULE4: D2 sets a direct bit in two bytes; D3 sets carry in one.
// RULE5: D5 is a three-byte direct decrement and branch with relative offset.
// RULE6: D6 and D7 exchange low nibbles with RAM through register 0 or 1.
// RULE7: D8 to DF are two-byte register decrement branches, index from low bits.
// RULE8: E0 reads external memory at the data pointer into the accumulator.
// RULE9: E2 and E3 read external memory through register 0 or 1.
// RULE10: E5 loads the accumulator from a direct address in two bytes.
// RULE11: E6 and E7 load the accumulator indirectly through register 0 or 1.
// RULE12: E8 to EF load the accumulator from working register 0 to 7.
// RULE13: F0 writes the accumulator to external memory at the data pointer.
// RULE14: F2 and F3 write the accumulator externally through register 0 or 1.
// RULE15: F5 stores the accumulator to a direct address in two bytes.
// RULE16: F6 and F7 store the accumulator indirectly through register 0 or 1.
// RULE17: F8 to FF store the accumulator into working register 0 to 7.
// RULE18: D4 decimal adjust, E4 clear, F4 complement, all one byte.
// RULE19: Relative offsets are signed bytes from the next instruction's first byte.
// RULE20: Absolute targets stay in the 2-kilobyte page of the next instruction.
module odu_decoder
	import odu_pkg::*;
#(
	parameter int PC_WIDTH = ODU_PC_WIDTH
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic fetch_valid,
	input wire logic [7:0] fetch_opcode,
	input wire logic [7:0] fetch_operand,
	input wire logic [7:0] fetch_operand2,
	input wire logic [PC_WIDTH-1:0] fetch_pc,
	output odu_op_t dec_op,
	output odu_form_t dec_form,
	output logic [1:0] dec_length,
	output logic [2:0] dec_reg_index,
	output logic dec_index_r1,
	output logic dec_valid,
	output logic dec_in_range,
	output logic [PC_WIDTH-1:0] dec_next_pc,
	output logic [PC_WIDTH-1:0] dec_target,
	output logic dec_target_valid,
	output logic [7:0] dec_data_addr
);
	odu_dec_if dec_bus ();

	// The table is purely combinational; all timing lives in this module.
	assign dec_bus.opcode = fetch_opcode;

	odu_decode_table u_table (
		.dec(dec_bus.table_side)
	);

	// Sign-extends the relative byte to the program counter width.
	function automatic logic [PC_WIDTH-1:0] odu_sext(input logic [7:0] offset);
		odu_sext = {{(PC_WIDTH-8){offset[7]}}, offset};
	endfunction

	// Widens the two-bit length to the program counter width.
	function automatic logic [PC_WIDTH-1:0] odu_widen(input logic [1:0] len);
		odu_widen = {{(PC_WIDTH-2){1'b0}}, len};
	endfunction

	logic [PC_WIDTH-1:0] seq_pc;
	logic [7:0] rel_byte;
	logic [PC_WIDTH-1:0] calc_target;

	// Address of the byte after the instruction, base of both target kinds.
	always_comb begin
		seq_pc = fetch_pc + odu_widen(dec_bus.length);
		// RULE19: offset byte choice
		rel_byte = (dec_bus.form == ODU_FORM_DIRECT_REL) ? fetch_operand2 : fetch_operand;
		calc_target = seq_pc;
		if (dec_bus.absolute) begin
			// RULE20: keep page bits
			calc_target = {seq_pc[PC_WIDTH-1:ODU_PAGE_BITS], dec_bus.page_bits, fetch_operand};
		end else if (dec_bus.relative) begin
			// RULE19: signed relative add
			calc_target = seq_pc + odu_sext(rel_byte);
		end
	end

	odu_op_t next_op;
	odu_form_t next_form;
	logic [1:0] next_length;
	logic [2:0] next_reg_index;
	logic next_index_r1;
	logic next_valid;
	logic next_in_range;
	logic [PC_WIDTH-1:0] next_next_pc;
	logic [PC_WIDTH-1:0] next_target;
	logic next_target_valid;
	logic [7:0] next_data_addr;

	// Results update only on a strobe and hold otherwise, so the datapath may sample late.
	always_comb begin
		next_op = dec_op;
		next_form = dec_form;
		next_length = dec_length;
		next_reg_index = dec_reg_index;
		next_index_r1 = dec_index_r1;
		next_in_range = dec_in_range;
		next_next_pc = dec_next_pc;
		next_target = dec_target;
		next_target_valid = dec_target_valid;
		next_data_addr = dec_data_addr;
		next_valid = 1'b0;
		if (fetch_valid) begin
			next_valid = 1'b1;
			next_in_range = dec_bus.valid;
			next_op = dec_bus.op;
			next_form = dec_bus.form;
			next_length = dec_bus.length;
			next_reg_index = dec_bus.reg_index;
			next_index_r1 = dec_bus.index_r1;
			next_next_pc = seq_pc;
			next_target = calc_target;
			next_target_valid = dec_bus.absolute | dec_bus.relative;
			next_data_addr = fetch_operand;
		end
	end

	// Synchronous reset leaves an idle, out-of-range decode.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dec_op <= ODU_OP_NONE;
			dec_form <= ODU_FORM_NONE;
			dec_length <= ODU_LEN_0;
			dec_reg_index <= '0;
			dec_index_r1 <= 1'b0;
			dec_valid <= 1'b0;
			dec_in_range <= 1'b0;
			dec_next_pc <= '0;
			dec_target <= '0;
			dec_target_valid <= 1'b0;
			dec_data_addr <= '0;
		end else begin
			dec_op <= next_op;
			dec_form <= next_form;
			dec_length <= next_length;
			dec_reg_index <= next_reg_index;
			dec_index_r1 <= next_index_r1;
			dec_valid <= next_valid;
			dec_in_range <= next_in_range;
			dec_next_pc <= next_next_pc;
			dec_target <= next_target;
			dec_target_valid <= next_target_valid;
			dec_data_addr <= next_data_addr;
		end
	end
endmodule

// *** odu_decoder_checker.sv ***
// Checker for the upper-range opcode decoder: answer timing, holding and decode relations at the top ports.
// Assumes it is bound to odu_decoder and sees only that module's ports on one clock.
`timescale 1ns/1ps
module odu_decoder_checker
	import odu_pkg::*;
#(
	parameter int PC_WIDTH = ODU_PC_WIDTH
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic fetch_valid,
	input wire logic [7:0] fetch_opcode,
	input wire logic [7:0] fetch_operand,
	input wire logic [7:0] fetch_operand2,
	input wire logic [PC_WIDTH-1:0] fetch_pc,
	input odu_op_t dec_op,
	input odu_form_t dec_form,
	input wire logic [1:0] dec_length,
	input wire logic [2:0] dec_reg_index,
	input wire logic dec_valid,
	input wire logic dec_in_range,
	input wire logic [PC_WIDTH-1:0] dec_next_pc,
	input wire logic [PC_WIDTH-1:0] dec_target,
	input wire logic dec_target_valid
);
	logic [PC_WIDTH-1:0] rel_ext;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Offset byte sign-extended; the direct form keeps it in the third byte.
	assign rel_ext = (fetch_opcode == 8'hD5) ? {{(PC_WIDTH-8){fetch_operand2[7]}}, fetch_operand2}
		: {{(PC_WIDTH-8){fetch_operand[7]}}, fetch_operand};

	// Strobe and answer pair one to one, one edge apart.
	a_answer_next: assert property (fetch_valid |=> dec_valid)
		else $error("decode answer missing after strobe");
	a_pulse_once: assert property (dec_valid |-> $past(fetch_valid) && $past(reset_n))
		else $error("decode answer without strobe");
	a_hold_idle: assert property (!fetch_valid |=> !dec_valid && $stable(dec_op) && $stable(dec_target))
		else $error("decode results moved without strobe");
	a_pull_decode: assert property (fetch_valid && fetch_opcode == 8'hD0 |=>
		dec_op == ODU_OP_STACK_PULL && dec_form == ODU_FORM_DIRECT && dec_length == 2'h2)
		else $error("stack pull decoded wrongly");
	a_reg_branch: assert property (fetch_valid && fetch_opcode[7:3] == 5'h1B |=>
		dec_op == ODU_OP_DECREMENT_BRANCH_NONZERO && dec_length == 2'h2 && dec_reg_index == $past(fetch_opcode[2:0]))
		else $error("register branch decoded wrongly");
	a_store_reg: assert property (fetch_valid && fetch_opcode[7:3] == 5'h1F |=>
		dec_op == ODU_OP_STORE_ACCUMULATOR && dec_length == 2'h1 && dec_reg_index == $past(fetch_opcode[2:0]))
		else $error("register store decoded wrongly");
	a_next_addr: assert property (dec_valid |-> dec_next_pc == $past(fetch_pc) + PC_WIDTH'(dec_length))
		else $error("next address is not address plus length");
	a_abs_target: assert property (fetch_valid && fetch_opcode inside {8'hD1, 8'hE1, 8'hF1} |=>
		dec_target_valid && dec_target == {dec_next_pc[PC_WIDTH-1:11], $past(fetch_opcode[7:5]), $past(fetch_operand)})
		else $error("absolute target outside page rule");
	a_rel_target: assert property (fetch_valid && (fetch_opcode == 8'hD5 || fetch_opcode[7:3] == 5'h1B) |=>
		dec_target_valid && dec_target == dec_next_pc + $past(rel_ext))
		else $error("relative target wrong");
	a_out_range: assert property (fetch_valid && fetch_opcode < 8'hD0 |=>
		!dec_in_range && dec_op == ODU_OP_NONE && dec_length == 2'h0 && !dec_target_valid)
		else $error("opcode below range decoded");
endmodule

bind odu_decoder odu_decoder_checker #(.PC_WIDTH(PC_WIDTH)) i_odu_decoder_checker (.clk(clk), .reset_n(reset_n),
	.fetch_valid(fetch_valid), .fetch_opcode(fetch_opcode), .fetch_operand(fetch_operand),
	.fetch_operand2(fetch_operand2), .fetch_pc(fetch_pc), .dec_op(dec_op), .dec_form(dec_form),
	.dec_length(dec_length), .dec_reg_index(dec_reg_index), .dec_valid(dec_valid), .dec_in_range(dec_in_range),
	.dec_next_pc(dec_next_pc), .dec_target(dec_target), .dec_target_valid(dec_target_valid));

// *** odu_fetch_model.sv ***
// Model of the program fetch unit that feeds the decoder one instruction per strobe.
// Assumes the decoder samples on the rising edge; this model changes its outputs on the falling edge.
`timescale 1ns/1ps
module odu_fetch_model (
	input wire logic clk,
	output logic fetch_valid,
	output logic [7:0] fetch_opcode,
	output logic [7:0] fetch_operand,
	output logic [7:0] fetch_operand2,
	output logic [15:0] fetch_pc
);
	// Quiet bus at time zero.
	initial begin
		fetch_valid = 1'b0;
		fetch_opcode = 8'h00;
		fetch_operand = 8'h00;
		fetch_operand2 = 8'h00;
		fetch_pc = 16'h0000;
	end

	// Presents one instruction; calling again at once keeps the strobe high for back-to-back fetches.
	task automatic send(input logic [7:0] opc, input logic [7:0] op1, input logic [7:0] op2, input logic [15:0] pc);
		@(negedge clk);
		fetch_valid <= 1'b1;
		fetch_opcode <= opc;
		fetch_operand <= op1;
		fetch_operand2 <= op2;
		fetch_pc <= pc;
	endtask

	// Bytes are not held between fetches, so they are inverted to catch a decoder that reads them late.
	task automatic idle();
		@(negedge clk);
		fetch_valid <= 1'b0;
		fetch_opcode <= ~fetch_opcode;
		fetch_operand <= ~fetch_operand;
		fetch_operand2 <= ~fetch_operand2;
		fetch_pc <= ~fetch_pc;
	endtask
endmodule

// *** odu_decoder_tb.sv ***
// Self-checking bench for the upper-range opcode decoder, fed by the fetch model.
// Assumes a 100 MHz clock and the default 16-bit program counter.
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %h seen %h", n, e, s); end end
module odu_decoder_tb;
	import odu_pkg::*;
	logic clk;
	logic reset_n;
	logic fetch_valid;
	logic [7:0] fetch_opcode;
	logic [7:0] fetch_operand;
	logic [7:0] fetch_operand2;
	logic [15:0] fetch_pc;
	odu_op_t dec_op;
	odu_form_t dec_form;
	logic [1:0] dec_length;
	logic [2:0] dec_reg_index;
	logic dec_index_r1;
	logic dec_valid;
	logic dec_in_range;
	logic [15:0] dec_next_pc;
	logic [15:0] dec_target;
	logic dec_target_valid;
	logic [7:0] dec_data_addr;
	int fails = 0;
	int cmp_count = 0;
	int cycles = 0;

	odu_fetch_model i_odu_fetch_model (.clk(clk), .fetch_valid(fetch_valid), .fetch_opcode(fetch_opcode),
		.fetch_operand(fetch_operand), .fetch_operand2(fetch_operand2), .fetch_pc(fetch_pc));
	odu_decoder i_odu_decoder (.clk(clk), .reset_n(reset_n), .fetch_valid(fetch_valid), .fetch_opcode(fetch_opcode),
		.fetch_operand(fetch_operand), .fetch_operand2(fetch_operand2), .fetch_pc(fetch_pc), .dec_op(dec_op),
		.dec_form(dec_form), .dec_length(dec_length), .dec_reg_index(dec_reg_index), .dec_index_r1(dec_index_r1),
		.dec_valid(dec_valid), .dec_in_range(dec_in_range), .dec_next_pc(dec_next_pc), .dec_target(dec_target),
		.dec_target_valid(dec_target_valid), .dec_data_addr(dec_data_addr));

	// Expected operation, operand form and length of each opcode.
	function automatic logic [9:0] exp_dec(input logic [7:0] o);
		case (o) inside
			8'hD0: return {ODU_OP_STACK_PULL, ODU_FORM_DIRECT, 2'h2};
			8'hD1, 8'hF1: return {ODU_OP_ABSOLUTE_CALL, ODU_FORM_CODE_ADDR, 2'h2};
			8'hE1: return {ODU_OP_ABSOLUTE_JUMP, ODU_FORM_CODE_ADDR, 2'h2};
			8'hD2: return {ODU_OP_SET_BIT, ODU_FORM_BIT_ADDR, 2'h2};
			8'hD3: return {ODU_OP_SET_BIT, ODU_FORM_CARRY, 2'h1};
			8'hD4: return {ODU_OP_DECIMAL_ADJUST, ODU_FORM_ACCUMULATOR, 2'h1};
			8'hE4: return {ODU_OP_CLEAR_ACCUMULATOR, ODU_FORM_ACCUMULATOR, 2'h1};
			8'hF4: return {ODU_OP_COMPLEMENT, ODU_FORM_ACCUMULATOR, 2'h1};
			8'hD5: return {ODU_OP_DECREMENT_BRANCH_NONZERO, ODU_FORM_DIRECT_REL, 2'h3};
			8'hD6, 8'hD7: return {ODU_OP_EXCHANGE_LOW_NIBBLE, ODU_FORM_INDIRECT, 2'h1};
			[8'hD8:8'hDF]: return {ODU_OP_DECREMENT_BRANCH_NONZERO, ODU_FORM_REGISTER_REL, 2'h2};
			8'hE0: return {ODU_OP_EXTERNAL_READ, ODU_FORM_DATA_POINTER, 2'h1};
			8'hF0: return {ODU_OP_EXTERNAL_WRITE, ODU_FORM_DATA_POINTER, 2'h1};
			8'hE2, 8'hE3: return {ODU_OP_EXTERNAL_READ, ODU_FORM_INDIRECT, 2'h1};
			8'hF2, 8'hF3: return {ODU_OP_EXTERNAL_WRITE, ODU_FORM_INDIRECT, 2'h1};
			8'hE5: return {ODU_OP_LOAD_ACCUMULATOR, ODU_FORM_DIRECT, 2'h2};
			8'hF5: return {ODU_OP_STORE_ACCUMULATOR, ODU_FORM_DIRECT, 2'h2};
			8'hE6, 8'hE7: return {ODU_OP_LOAD_ACCUMULATOR, ODU_FORM_INDIRECT, 2'h1};
			8'hF6, 8'hF7: return {ODU_OP_STORE_ACCUMULATOR, ODU_FORM_INDIRECT, 2'h1};
			[8'hE8:8'hEF]: return {ODU_OP_LOAD_ACCUMULATOR, ODU_FORM_REGISTER, 2'h1};
			[8'hF8:8'hFF]: return {ODU_OP_STORE_ACCUMULATOR, ODU_FORM_REGISTER, 2'h1};
			default: return {ODU_OP_NONE, ODU_FORM_NONE, 2'h0};
		endcase
	endfunction

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Every opcode D0 to FF, strobed back to back with no idle cycle.
	task automatic t_sweep();
		logic [7:0] o;
		logic [9:0] e;
		for (int i = 208; i < 256; i++) begin
			o = i[7:0];
			e = exp_dec(o);
			i_odu_fetch_model.send(o, o ^ 8'h5A, 8'hA5, 16'h1000 + 16'(i));
			@(posedge clk);
			#1;
			`CHK("decode", e, {dec_op, dec_form, dec_length})
			`CHK("reg_index", o[2:0], dec_reg_index)
			`CHK("index_r1", o[0], dec_index_r1)
			`CHK("valid", 2'h3, {dec_valid, dec_in_range})
			`CHK("next_pc", 16'h1000 + 16'(i) + 16'(e[1:0]), dec_next_pc)
			`CHK("target_valid", o inside {8'hD1, 8'hE1, 8'hF1, 8'hD5} || o[7:3] == 5'h1B, dec_target_valid)
			`CHK("data_addr", o ^ 8'h5A, dec_data_addr)
		end
		i_odu_fetch_model.idle();
	endtask

	// Targets at page edges, address wrap and both offset extremes.
	task automatic t_target(input logic [7:0] o, input logic [7:0] op1, input logic [7:0] op2, input logic [15:0] pc);
		logic [15:0] nx;
		logic [7:0] off;
		nx = pc + 16'(exp_dec(o)) % 16'h4;
		off = (o == 8'hD5) ? op2 : op1;
		i_odu_fetch_model.send(o, op1, op2, pc);
		@(posedge clk);
		#1;
		if (o[4:0] == 5'h11 || o == 8'hE1)
			`CHK("abs_target", {nx[15:11], o[7:5], op1}, dec_target)
		else
			`CHK("rel_target", nx + {{8{off[7]}}, off}, dec_target)
	endtask

	task automatic t_targets();
		t_target(8'hD1, 8'h34, 8'h00, 16'h07FE);
		t_target(8'hF1, 8'hFF, 8'h00, 16'hFFFE);
		t_target(8'hE1, 8'h12, 8'h00, 16'h2345);
		t_target(8'hD8, 8'h80, 8'h00, 16'h0100);
		t_target(8'hDF, 8'h7F, 8'h80, 16'h0100);
		t_target(8'hD5, 8'h7F, 8'hFE, 16'h0FFF);
		i_odu_fetch_model.idle();
	endtask

	// Opcodes below the range answer but decode to nothing.
	task automatic t_out_range();
		i_odu_fetch_model.send(8'hCF, 8'h11, 8'h22, 16'h0300);
		@(posedge clk);
		#1;
		`CHK("low_decode", {ODU_OP_NONE, ODU_FORM_NONE, 2'h0, 1'b0, 1'b0, 1'b1}, {dec_op, dec_form, dec_length,
			dec_in_range, dec_target_valid, dec_valid})
		`CHK("low_next", 32'h03000300, {dec_next_pc, dec_target})
		i_odu_fetch_model.idle();
	endtask

	// Results hold while idle, then a mid-run reset clears them.
	task automatic t_hold_reset();
		i_odu_fetch_model.send(8'hE5, 8'h44, 8'h00, 16'h0200);
		i_odu_fetch_model.idle();
		repeat (2) @(posedge clk);
		#1;
		`CHK("held", {ODU_OP_LOAD_ACCUMULATOR, 8'h44, 16'h0202, 1'b0},
			{dec_op, dec_data_addr, dec_next_pc, dec_valid})
		@(negedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("reset", {ODU_OP_NONE, ODU_FORM_NONE, 2'h0, 16'h0000, 1'b0}, {dec_op, dec_form, dec_length, dec_next_pc,
			dec_valid})
		@(negedge clk);
		reset_n <= 1'b1;
		// The first strobe after release must be taken, not lost to a lingering reset.
		i_odu_fetch_model.send(8'hD0, 8'h21, 8'h00, 16'h0400);
		@(posedge clk);
		#1;
		`CHK("after_reset", {ODU_OP_STACK_PULL, 8'h21, 16'h0402, 1'b1},
			{dec_op, dec_data_addr, dec_next_pc, dec_valid})
		i_odu_fetch_model.idle();
	endtask

	// Free-running core clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Cuts a hang short well beyond the hundred or fewer cycles the run needs.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			stop_test();
		end
	end

	// Reset, then the scenarios in turn.
	initial begin
		reset_n = 1'b0;
		repeat (8) @(negedge clk);
		reset_n <= 1'b1;
		t_sweep();
		t_targets();
		t_out_range();
		t_hold_reset();
		stop_test();
	end
endmodule
